// [hw/tcf_pkg.sv]
// Constants and types for the timer control and read-sync front end
// Summary of operation
// - Registers take 8, 16 and 32-bit writes through byte strobes
// - Writes are ignored while the external access protection is active
// - Enable-protected fields change only while the timer is disabled
// - Wrap on next clock, next prescaled tick, or next clock clearing divider
// - Timer halts in standby unless standby run is set
// - Prescaler divides by 1,2,4,8,16,64,256,1024 for codes 0..7
// - Frequency modes toggle output on match; code 1 uses compare zero as top
// - PWM modes clear on up-match, set on down-match, inverse on wrap
// - Normal top is the period in 8-bit mode, else the counter maximum
// - Width code 0 is 16-bit, 1 is 8-bit, 2 is 32-bit
// - Mode, width, prescaler, standby and wrap fields act without sync delay
// - Enable reads back at once, sets busy, takes effect after sync
// - Soft reset restores all registers and disables the timer
// - A soft reset write discards every other field of that write
// - Soft reset bit and its busy flag stay set until reset completes
// - Read request syncs the addressed register, sets busy, reads zero
// - Continuous read resyncs the selected register again after each capture
// - Continuous read needs one read request after setting it
// - Counter write may stall in continuous sync, at most 6 clocks
// - Read address selects the counter or compare register offset
package tcf_pkg;
   // Byte addresses of the registers (index times four)
   localparam logic [7:0] TCF_CTRL_IDX   = 8'h00;
   localparam logic [7:0] TCF_READ_REQUEST_STROBE_IDX   = 8'h02;
   localparam logic [7:0] TCF_ADDR_CTRL  = 8'h00;
   localparam logic [7:0] TCF_ADDR_READ_REQUEST_STROBE  = 8'h08;
   localparam logic [7:0] TCF_ADDR_AUX   = 8'h0c;
   localparam logic [7:0] TCF_ADDR_STAT  = 8'h10;
   localparam logic [7:0] TCF_ADDR_COUNT = 8'h14;
   localparam logic [7:0] TCF_ADDR_CC0   = 8'h18;
   localparam logic [7:0] TCF_ADDR_PER   = 8'h1c;
   localparam logic [7:0] TCF_ADDR_SDATA = 8'h20;
   // Read-sync targets, as offsets in the timer's own byte map
   localparam logic [4:0] TCF_RSEL_COUNT = 5'h10;
   localparam logic [4:0] TCF_RSEL_CC0   = 5'h18;
   // Control word fields
   localparam int TCF_SOFT_RESET_BIT  = 0;
   localparam int TCF_ENABLE_BIT = 1;
   localparam int TCF_WIDTH_LSB  = 2;
   localparam int TCF_WAVE_LSB   = 5;
   localparam int TCF_PRESC_LSB  = 8;
   localparam int TCF_STBY_BIT   = 11;
   localparam int TCF_WRAP_LSB   = 12;
   localparam logic [15:0] TCF_CTRL_MASK  = 16'h3f6f;
   localparam logic [15:0] TCF_CTRL_RESET = 16'h0000;
   // Read request fields
   localparam int TCF_READ_REQUEST_STROBE_BIT  = 15;
   localparam int TCF_CONTINUOUS_READ_BIT = 14;
   // Stand-in for the bus/timer clock crossing time
   localparam logic [3:0] TCF_SYNC_CYCLES = 4'h6;
   // Width codes
   localparam logic [1:0] TCF_W16 = 2'h0;
   localparam logic [1:0] TCF_W8  = 2'h1;
   localparam logic [1:0] TCF_W32 = 2'h2;
   // Wrap timing codes
   localparam logic [1:0] TCF_WRAP_GEN   = 2'h0;
   localparam logic [1:0] TCF_WRAP_PRESC = 2'h1;
   localparam logic [1:0] TCF_WRAP_CLEAR = 2'h2;
   // Waveform modes
   localparam logic [1:0] TCF_NORMAL_FREQUENCY_MODE = 2'h0;
   localparam logic [1:0] TCF_MATCH_FREQUENCY_MODE = 2'h1;
   localparam logic [1:0] TCF_NORMAL_PWM_MODE = 2'h2;
   localparam logic [1:0] TCF_MATCH_PWM_MODE = 2'h3;

   typedef enum logic [1:0]
   {
      TCF_SYNC_IDLE  = 2'b00,
      TCF_SYNC_EN    = 2'b01,
      TCF_SYNC_RST   = 2'b10,
      TCF_SYNC_READ  = 2'b11
   } tcf_sync_t;
endpackage

// [hw/tcf_timer_ctrl.sv]
// Timer control front end: APB registers, prescaler, counter, sync model
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tcf_timer_ctrl
(
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        SYS_RST,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // System conditions, asynchronous pins
   input  wire logic        PROT_ACTIVE,
   input  wire logic        STANDBY_REQ,
   // Timer outputs
   output logic             WAVE_OUT,
   output logic             TIMER_ENABLED
);
   import tcf_pkg::*;

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed
   {
      logic [1:0]  prot_s;
      logic [1:0]  stby_s;
      logic [15:0] ctrl;
      logic        read_request_strobe_pend;
      logic        continuous_read;
      logic [4:0]  raddr;
      logic        dir;
      logic        enabled;
      tcf_sync_t   sync_st;
      logic [3:0]  sync_cnt;
      logic [9:0]  presc;
      logic [31:0] count;
      logic [31:0] cc0;
      logic [7:0]  period_value;
      logic [31:0] sdata;
      logic        wave;
      logic [31:0] rdata;
      logic        slverr;
   } tcf_state_t;

   tcf_state_t s_r;
   tcf_state_t s_nxt;

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (st[i])
         begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [9:0] presc_limit(input logic [2:0] code);
      logic [9:0] l;
      case (code)
         3'h0:    l = 10'h000;
         3'h1:    l = 10'h001;
         3'h2:    l = 10'h003;
         3'h3:    l = 10'h007;
         3'h4:    l = 10'h00f;
         3'h5:    l = 10'h03f;
         3'h6:    l = 10'h0ff;
         default: l = 10'h3ff;
      endcase
      return l;
   endfunction

   function automatic logic [31:0] width_max(input logic [1:0] w);
      logic [31:0] m;
      case (w)
         TCF_W8:  m = 32'h0000_00ff;
         TCF_W32: m = 32'hffff_ffff;
         default: m = 32'h0000_ffff;
      endcase
      return m;
   endfunction

   function automatic logic [1:0] legal_code(input logic [1:0] c);
      return (c == 2'h3) ? 2'h0 : c;
   endfunction

   // ==========================================================
   // Next state
   // ==========================================================
   logic        setup;
   logic        access;
   logic        wr;
   logic        stall;
   logic        unmapped;
   logic        protect;
   logic [1:0]  width;
   logic [1:0]  wave_md;
   logic [1:0]  wrap_md;
   logic [31:0] maxv;
   logic [31:0] top;
   logic [31:0] wctrl;
   logic [31:0] wreq;
   logic        tick;
   logic        at_end;
   logic        run;
   logic        match;
   logic [31:0] rd_hold;
   logic        err_hold;

   always_comb
   begin
      s_nxt    = s_r;
      width    = s_r.ctrl[TCF_WIDTH_LSB +: 2];
      wave_md  = s_r.ctrl[TCF_WAVE_LSB +: 2];
      wrap_md  = s_r.ctrl[TCF_WRAP_LSB +: 2];
      maxv     = width_max(width);
      // Top value per waveform mode and width
      if (wave_md == TCF_MATCH_FREQUENCY_MODE || wave_md == TCF_MATCH_PWM_MODE)
      begin
         top = s_r.cc0 & maxv;
      end
      else if (width == TCF_W8)
      begin
         top = {24'h000000, s_r.period_value};
      end
      else
      begin
         top = maxv;
      end
      // Pins pass two flops before anything reads them
      s_nxt.prot_s = {s_r.prot_s[0], PROT_ACTIVE};
      s_nxt.stby_s = {s_r.stby_s[0], STANDBY_REQ};
      protect  = s_r.prot_s[1];

      // Bus decode
      setup    = PSEL & ~PENABLE;
      unmapped = !(PADDR == TCF_ADDR_CTRL || PADDR == TCF_ADDR_READ_REQUEST_STROBE ||
                   PADDR == TCF_ADDR_AUX || PADDR == TCF_ADDR_STAT ||
                   PADDR == TCF_ADDR_COUNT || PADDR == TCF_ADDR_CC0 ||
                   PADDR == TCF_ADDR_PER || PADDR == TCF_ADDR_SDATA);
      // In continuous read, a counter write must not race the read capture in flight
      stall    = PSEL & PENABLE & PWRITE & (PADDR == TCF_ADDR_COUNT) &
                 s_r.continuous_read & (s_r.sync_st == TCF_SYNC_READ);
      access   = PSEL & PENABLE & ~stall;
      wr       = access & PWRITE & ~unmapped & ~protect;
      wctrl    = merge({16'h0000, s_r.ctrl}, PWDATA, PSTRB);
      wreq     = merge({16'h0000, 1'b0, s_r.continuous_read,
                        9'h000, s_r.raddr}, PWDATA, PSTRB);

      if (setup)
      begin
         s_nxt.slverr = unmapped;
         case (PADDR)
            TCF_ADDR_CTRL:  s_nxt.rdata = {16'h0000, s_r.ctrl};
            // Request bit always reads as zero
            TCF_ADDR_READ_REQUEST_STROBE:  s_nxt.rdata = {16'h0000, 1'b0, s_r.continuous_read,
                                           9'h000, s_r.raddr};
            TCF_ADDR_AUX:   s_nxt.rdata = {31'h0, s_r.dir};
            TCF_ADDR_STAT:  s_nxt.rdata = {27'h0, s_r.wave, s_r.enabled,
                                 s_r.sync_st == TCF_SYNC_READ,
                                 s_r.sync_st == TCF_SYNC_EN,
                                 s_r.sync_st == TCF_SYNC_RST};
            TCF_ADDR_COUNT: s_nxt.rdata = s_r.count;
            TCF_ADDR_CC0:   s_nxt.rdata = s_r.cc0;
            TCF_ADDR_PER:   s_nxt.rdata = {24'h000000, s_r.period_value};
            TCF_ADDR_SDATA: s_nxt.rdata = s_r.sdata;
            default:        s_nxt.rdata = 32'h0000_0000;
         endcase
      end

      // Prescaler and counter
      run    = s_r.enabled &
               ~(s_r.stby_s[1] & ~s_r.ctrl[TCF_STBY_BIT]);
      tick   = s_r.presc == presc_limit(s_r.ctrl[TCF_PRESC_LSB +: 3]);
      at_end = s_r.dir ? (s_r.count == 32'h0) : (s_r.count == top);
      match  = (s_r.count == (s_r.cc0 & maxv));
      if (run)
      begin
         s_nxt.presc = tick ? 10'h000 : s_r.presc + 10'h001;
         if (at_end && (wrap_md != TCF_WRAP_PRESC || tick))
         begin
            s_nxt.count = s_r.dir ? top : 32'h0;
            if (wrap_md == TCF_WRAP_CLEAR)
            begin
               s_nxt.presc = 10'h000;
            end
            if (wave_md == TCF_NORMAL_PWM_MODE || wave_md == TCF_MATCH_PWM_MODE)
            begin
               s_nxt.wave = ~s_r.dir;
            end
         end
         else if (tick)
         begin
            s_nxt.count = (s_r.dir ? s_r.count - 32'h1
                                   : s_r.count + 32'h1) & maxv;
         end
         if (tick && match && !at_end || tick && match &&
             (wave_md == TCF_MATCH_FREQUENCY_MODE || wave_md == TCF_NORMAL_FREQUENCY_MODE))
         begin
            if (wave_md == TCF_NORMAL_FREQUENCY_MODE || wave_md == TCF_MATCH_FREQUENCY_MODE)
            begin
               s_nxt.wave = ~s_r.wave;
            end
            else if (!at_end)
            begin
               s_nxt.wave = s_r.dir;
            end
         end
      end
      else
      begin
         s_nxt.presc = 10'h000;
      end

      // Synchronisation sequencer
      case (s_r.sync_st)
         TCF_SYNC_IDLE:
         begin
            if (s_r.read_request_strobe_pend)
            begin
               s_nxt.sync_st  = TCF_SYNC_READ;
               s_nxt.sync_cnt = TCF_SYNC_CYCLES;
            end
         end
         TCF_SYNC_EN, TCF_SYNC_RST, TCF_SYNC_READ:
         begin
            s_nxt.sync_cnt = s_r.sync_cnt - 4'h1;
            if (s_r.sync_cnt == 4'h1)
            begin
               s_nxt.sync_st = TCF_SYNC_IDLE;
               if (s_r.sync_st == TCF_SYNC_EN)
               begin
                  s_nxt.enabled = s_r.ctrl[TCF_ENABLE_BIT];
               end
               else if (s_r.sync_st == TCF_SYNC_READ)
               begin
                  s_nxt.sdata = (s_r.raddr == TCF_RSEL_CC0) ? s_r.cc0
                                : s_r.count;
                  // Continuous mode keeps the request armed
                  s_nxt.read_request_strobe_pend = s_r.continuous_read;
               end
            end
         end
         default:
         begin
            s_nxt.sync_st = TCF_SYNC_IDLE;
         end
      endcase

      // Register writes
      if (wr)
      begin
         case (PADDR)
            TCF_ADDR_CTRL:
            begin
               if (PSTRB[0] && PWDATA[TCF_SOFT_RESET_BIT])
               begin
                  s_nxt.ctrl          = TCF_CTRL_RESET;
                  s_nxt.ctrl[TCF_SOFT_RESET_BIT] = 1'b1;
                  s_nxt.enabled       = 1'b0;
                  s_nxt.sync_st       = TCF_SYNC_RST;
                  s_nxt.sync_cnt      = TCF_SYNC_CYCLES;
               end
               else if (s_r.sync_st != TCF_SYNC_RST)
               begin
                  if (!s_r.enabled && !s_r.ctrl[TCF_ENABLE_BIT])
                  begin
                     s_nxt.ctrl = wctrl[15:0] & TCF_CTRL_MASK;
                     s_nxt.ctrl[TCF_WIDTH_LSB +: 2] =
                        legal_code(wctrl[TCF_WIDTH_LSB +: 2]);
                     s_nxt.ctrl[TCF_WRAP_LSB +: 2] =
                        legal_code(wctrl[TCF_WRAP_LSB +: 2]);
                  end
                  if (PSTRB[0] &&
                      wctrl[TCF_ENABLE_BIT] != s_r.ctrl[TCF_ENABLE_BIT])
                  begin
                     s_nxt.ctrl[TCF_ENABLE_BIT] =
                        wctrl[TCF_ENABLE_BIT];
                     s_nxt.sync_st  = TCF_SYNC_EN;
                     s_nxt.sync_cnt = TCF_SYNC_CYCLES;
                  end
               end
            end
            TCF_ADDR_READ_REQUEST_STROBE:
            begin
               s_nxt.raddr = wreq[4:0];
               s_nxt.continuous_read = wreq[TCF_CONTINUOUS_READ_BIT];
               if (PSTRB[1] && PWDATA[TCF_READ_REQUEST_STROBE_BIT])
               begin
                  s_nxt.read_request_strobe_pend = 1'b1;
               end
            end
            TCF_ADDR_AUX:
            begin
               if (!s_r.enabled && PSTRB[0])
               begin
                  s_nxt.dir = PWDATA[0];
               end
            end
            TCF_ADDR_COUNT:
            begin
               s_nxt.count = merge(s_r.count, PWDATA, PSTRB) & maxv;
            end
            TCF_ADDR_CC0:   s_nxt.cc0   = merge(s_r.cc0, PWDATA, PSTRB);
            TCF_ADDR_PER:
            begin
               if (PSTRB[0])
               begin
                  s_nxt.period_value = PWDATA[7:0];
               end
            end
            default:
            begin
               s_nxt.period_value = s_r.period_value;
            end
         endcase
      end

      // A read set up at this edge keeps the value it latched
      rd_hold  = s_nxt.rdata;
      err_hold = s_nxt.slverr;
      // Reset completes: everything but the synchronisers and bus answer returns to its initial state
      if (s_r.sync_st == TCF_SYNC_RST && s_r.sync_cnt == 4'h1)
      begin
         s_nxt = '0;
         // Only the synchronisers and bus answer survive the soft reset
         s_nxt.prot_s  = {s_r.prot_s[0], PROT_ACTIVE};
         s_nxt.stby_s  = {s_r.stby_s[0], STANDBY_REQ};
         s_nxt.rdata   = rd_hold;
         s_nxt.slverr  = err_hold;
         s_nxt.sync_st = TCF_SYNC_IDLE;
      end
   end

   // ==========================================================
   // Registers and outputs
   // ==========================================================
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign PRDATA        = s_r.rdata;
   assign PSLVERR       = s_r.slverr & PSEL & PENABLE;
   assign PREADY        = ~stall;
   assign WAVE_OUT      = s_r.wave;
   assign TIMER_ENABLED = s_r.enabled;
endmodule
`default_nettype wire

// [tb/tcf_timer_ctrl_asserts.sv]
// Port-level assertions for the timer control front end
`timescale 1ns/1ps
`default_nettype none
module tcf_timer_ctrl_asserts
   import tcf_pkg::*;
(
   // Clock and reset
   input wire logic        CLK_SYS,
   input wire logic        SYS_RST,
   // APB slave side
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0]  PSTRB,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   // System pins and timer outputs
   input wire logic        PROT_ACTIVE,
   input wire logic        STANDBY_REQ,
   input wire logic        WAVE_OUT,
   input wire logic        TIMER_ENABLED
);
   logic acc;

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (SYS_RST);

   assign acc = PSEL && PENABLE;

   // =========================================================
   // Bus handshake
   a_slverr_phase: assert property (PSLVERR |-> acc)
      else $error("error flag outside access phase");
   a_slverr_unmapped: assert property (acc && PADDR == 8'h24 |-> PSLVERR)
      else $error("unmapped access without error flag");
   a_ready_idle: assert property
      (!(PSEL && PWRITE && PADDR == TCF_ADDR_COUNT) |-> PREADY)
      else $error("ready low outside a counter write");
   a_stall_bound: assert property (acc && !PREADY |-> ##[1:12] PREADY)
      else $error("counter write stalled too long");
   a_prdata_stands: assert property
      (PSEL && !PENABLE |=> ##1 $stable(PRDATA))
      else $error("read data moved during the access");
   a_read_request_strobe_reads_zero: assert property
      (PSEL && !PENABLE && !PWRITE && PADDR == TCF_ADDR_READ_REQUEST_STROBE
       |=> !PRDATA[TCF_READ_REQUEST_STROBE_BIT])
      else $error("read request bit read back as one");

   // =========================================================
   // Enable and reset
   a_enable_delayed: assert property
      (acc && PREADY && PWRITE && PADDR == TCF_ADDR_CTRL &&
       !(PSTRB[0] && PWDATA[TCF_SOFT_RESET_BIT])
       |=> $stable(TIMER_ENABLED) [*3])
      else $error("enable changed without sync delay");
   a_reset_state: assert property (disable iff (1'b0)
      $fell(SYS_RST) |-> PREADY && !TIMER_ENABLED && !WAVE_OUT
      && !PSLVERR && PRDATA == 32'h0)
      else $error("outputs not at reset state");

   c_stall: cover property (acc && !PREADY);
   c_slverr: cover property (acc && PSLVERR);
   c_enabled: cover property ($rose(TIMER_ENABLED));
   c_wave: cover property ($rose(WAVE_OUT));
endmodule

bind tcf_timer_ctrl tcf_timer_ctrl_asserts u_chk
(
   .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .PROT_ACTIVE(PROT_ACTIVE), .STANDBY_REQ(STANDBY_REQ),
   .WAVE_OUT(WAVE_OUT), .TIMER_ENABLED(TIMER_ENABLED)
);
`default_nettype wire

// [tb/tb.sv]
// Self-checking testbench for the timer control front end
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tcf_pkg::*;
   logic        CLK_SYS = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [7:0]  PADDR = 0;
   logic [31:0] PWDATA = 0, PRDATA, rdat, keep;
   logic [3:0]  PSTRB = 0;
   logic        PREADY, PSLVERR, WAVE_OUT, TIMER_ENABLED, rerr;
   logic        PROT_ACTIVE = 0, STANDBY_REQ = 0;
   int          n_mismatch = 0, check_count = 0, waits;

   always #10 CLK_SYS = ~CLK_SYS;

   tcf_timer_ctrl DUT
   (
      .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .PROT_ACTIVE(PROT_ACTIVE), .STANDBY_REQ(STANDBY_REQ),
      .WAVE_OUT(WAVE_OUT), .TIMER_ENABLED(TIMER_ENABLED)
   );

   // =========================================================
   // Shared tasks
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Ready, data and error are read at the rising edge that ends the
   // access, before that edge has updated anything
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      PSTRB <= s;
      waits = 0;
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      @(posedge CLK_SYS);
      while (PREADY !== 1'b1 && waits < 40)
      begin
         waits++;
         @(posedge CLK_SYS);
      end
      if (waits >= 40)
         n_mismatch++;
      rdat = PRDATA;
      rerr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK_SYS);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0, 4'h0);
   endtask

   task automatic wait_idle;
      int i;
      i = 0;
      rd(TCF_ADDR_STAT);
      while (rdat[2:0] !== 3'h0 && i < 30)
      begin
         i++;
         rd(TCF_ADDR_STAT);
      end
      if (i >= 30)
         n_mismatch++;
   endtask

   task automatic test_done;
      $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // =========================================================
   // Scenarios
   task automatic t_reset_vals;
      rd(TCF_ADDR_CTRL);
      check(rdat, 32'h0);
      rd(TCF_ADDR_READ_REQUEST_STROBE);
      check(rdat, 32'h0);
      rd(8'h24);
      check({rdat, rerr}, 33'h1);
   endtask

   // One loop walks every code of every plain control field
   task automatic t_fields;
      logic [31:0] d, e;
      logic [1:0]  c;
      for (int i = 0; i < 8; i++)
      begin
         c = i[1:0];
         d = {18'h0, c, i[0], i[2:0], 1'b0, c, 1'b0, c, 2'h0};
         e = d;
         if (c == 2'h3)
         begin
            e[13:12] = 2'h0;
            e[3:2] = 2'h0;
         end
         wr(TCF_ADDR_CTRL, d);
         rd(TCF_ADDR_CTRL);
         check(rdat, e);
         rd(TCF_ADDR_STAT);
         check(rdat[2:0], 3'h0);
      end
      wr(TCF_ADDR_CTRL, 32'h0024);
      apb(1'b1, TCF_ADDR_CTRL, 32'h0000_0500, 4'h2);
      rd(TCF_ADDR_CTRL);
      check(rdat, 32'h0524);
   endtask

   task automatic t_enable;
      wr(TCF_ADDR_CTRL, 32'h0);
      wr(TCF_ADDR_CTRL, 32'h2);
      check(TIMER_ENABLED, 1'b0);
      rd(TCF_ADDR_CTRL);
      check(rdat, 32'h2);
      rd(TCF_ADDR_STAT);
      check(rdat[1], 1'b1);
      wait_idle();
      check(TIMER_ENABLED, 1'b1);
      wr(TCF_ADDR_CTRL, 32'h6);
      rd(TCF_ADDR_CTRL);
      check(rdat, 32'h2);
      STANDBY_REQ <= 1'b1;
      repeat (3) @(posedge CLK_SYS);
      rd(TCF_ADDR_COUNT);
      keep = rdat;
      repeat (10) @(posedge CLK_SYS);
      rd(TCF_ADDR_COUNT);
      check(rdat, keep);
      STANDBY_REQ <= 1'b0;
      repeat (3) @(posedge CLK_SYS);
      rd(TCF_ADDR_COUNT);
      check(rdat !== keep, 1'b1);
      wr(TCF_ADDR_CTRL, 32'h0);
      wait_idle();
      check(TIMER_ENABLED, 1'b0);
   endtask

   task automatic t_prot;
      PROT_ACTIVE <= 1'b1;
      repeat (3) @(posedge CLK_SYS);
      wr(TCF_ADDR_CTRL, 32'h4);
      rd(TCF_ADDR_CTRL);
      check(rdat, 32'h0);
      PROT_ACTIVE <= 1'b0;
      repeat (3) @(posedge CLK_SYS);
   endtask

   task automatic t_read_sync;
      wr(TCF_ADDR_COUNT, 32'h1234);
      wr(TCF_ADDR_CC0, 32'h55aa);
      wr(TCF_ADDR_READ_REQUEST_STROBE, 32'h8010);
      rd(TCF_ADDR_READ_REQUEST_STROBE);
      check(rdat, 32'h0010);
      rd(TCF_ADDR_STAT);
      check(rdat[2], 1'b1);
      wait_idle();
      rd(TCF_ADDR_SDATA);
      check(rdat, 32'h1234);
      wr(TCF_ADDR_READ_REQUEST_STROBE, 32'h8018);
      wait_idle();
      rd(TCF_ADDR_SDATA);
      check(rdat, 32'h55aa);
   endtask

   task automatic t_continuous;
      wr(TCF_ADDR_READ_REQUEST_STROBE, 32'h4010);
      rd(TCF_ADDR_STAT);
      check(rdat[2], 1'b0);
      wr(TCF_ADDR_READ_REQUEST_STROBE, 32'hc010);
      wr(TCF_ADDR_COUNT, 32'hbeef);
      check(waits <= 12, 1'b1);
      repeat (20) @(posedge CLK_SYS);
      rd(TCF_ADDR_SDATA);
      check(rdat, 32'hbeef);
      wr(TCF_ADDR_READ_REQUEST_STROBE, 32'h0);
      wait_idle();
   endtask

   task automatic t_soft_reset;
      wr(TCF_ADDR_CTRL, 32'h4);
      wr(TCF_ADDR_READ_REQUEST_STROBE, 32'h4010);
      wr(TCF_ADDR_CTRL, 32'h0907);
      rd(TCF_ADDR_CTRL);
      check(rdat, 32'h1);
      rd(TCF_ADDR_STAT);
      check(rdat[0], 1'b1);
      wait_idle();
      rd(TCF_ADDR_CTRL);
      check(rdat, 32'h0);
      rd(TCF_ADDR_READ_REQUEST_STROBE);
      check({rdat, TIMER_ENABLED}, 33'h0);
   endtask

   // Waveform shapes on an 8-bit counter whose top is three
   task automatic t_wave;
      int   hi, tg;
      logic w;
      hi = 0;
      tg = 0;
      wr(TCF_ADDR_PER, 32'h3);
      wr(TCF_ADDR_CC0, 32'h1);
      wr(TCF_ADDR_CTRL, 32'h0046);
      wait_idle();
      repeat (8)
      begin
         @(posedge CLK_SYS);
         hi += WAVE_OUT;
      end
      check(hi, 32'h4);
      wr(TCF_ADDR_CTRL, 32'h0);
      wait_idle();
      wr(TCF_ADDR_CC0, 32'h3);
      wr(TCF_ADDR_CTRL, 32'h0026);
      wait_idle();
      w = WAVE_OUT;
      repeat (16)
      begin
         @(posedge CLK_SYS);
         tg += (WAVE_OUT != w);
         w = WAVE_OUT;
      end
      check(tg, 32'h4);
      wr(TCF_ADDR_CTRL, 32'h0);
      wait_idle();
   endtask

   // =========================================================
   // Main sequence and watchdog
   initial
   begin
      repeat (6) @(posedge CLK_SYS);
      SYS_RST <= 1'b0;
      @(posedge CLK_SYS);
      t_reset_vals();
      t_fields();
      t_enable();
      t_prot();
      t_read_sync();
      t_continuous();
      t_soft_reset();
      t_wave();
      test_done();
   end

   // The whole sequence needs well under a tenth of this span
   initial
   begin
      repeat (20000) @(posedge CLK_SYS);
      n_mismatch++;
      test_done();
   end
endmodule
`default_nettype wire
